// ---- hw/rch_core.sv ----
`default_nettype none
`include "rch_defines.svh"
module rch_core import rch_pkg::*; (
  input wire logic CLK_SYS, // 125 MHz system clock
  input wire logic RESETN, // async active-low reset
  input wire logic INSTR_VALID, // one-cycle instruction issue pulse
  input wire logic [31:0] INSTR, // instruction word
  input wire logic [31:0] DST_VAL, // destination register value
  input wire logic [31:0] SRC_VAL, // source register value
  input wire logic C_IN, // carry flag before instruction
  input wire logic Z_IN, // zero flag before instruction
  input wire logic [3:0] HUB_SLOT, // hub round-robin slot counter
  input wire logic [3:0] CORE_ID, // this core's hub slot
  input wire logic [7:0] HUB_RDATA, // hub byte read data, valid the cycle after HUB_REQ
  input wire logic CTR_A_EN, // counter a stimulus qualifies accumulate
  input wire logic CTR_B_EN, // counter b stimulus qualifies accumulate
  input wire logic [31:0] CTR_A_INCR, // counter_a_increment register
  input wire logic [31:0] CTR_B_INCR, // counter_b_increment register
  output logic BUSY, // core stalled by this slice
  output logic DONE, // one-cycle completion pulse
  output logic RES_WE, // write destination with RES in DONE cycle
  output logic [8:0] RES_ADDR, // destination register address
  output logic [31:0] RES, // result value
  output logic Z_OUT, // zero flag after instruction
  output logic C_OUT, // carry flag after instruction
  output logic HUB_REQ, // hub access strobe, registered in the cycle after the granted slot
  output logic HUB_WE, // hub byte write
  output logic [15:0] HUB_ADDR, // hub byte address
  output logic [7:0] HUB_WDATA, // hub write byte
  output logic [31:0] PHASE_A, // counter a accumulator
  output logic [31:0] PHASE_B // counter b accumulator
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_m_r, rst_n_r;
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      rst_m_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_n_r <= rst_m_r;
    end
  end

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  function automatic logic [31:0] rot_carry(input logic [31:0] d, input logic [4:0] n,
                                            input logic c, input logic left);
    logic [63:0] w;
    w = '0;
    if (left) begin
      w = {d, {32{c}}} << n;
      rot_carry = w[63:32];
    end else begin
      w = {{32{c}}, d} >> n;
      rot_carry = w[31:0];
    end
  endfunction

  function automatic logic is_phase(input logic [8:0] a);
    is_phase = (a == `RCH_ADDR_PHA) || (a == `RCH_ADDR_PHB);
  endfunction

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  logic [5:0] f_op;
  logic f_wz, f_wc, f_wr, f_imm;
  logic [3:0] f_cond;
  logic [8:0] f_dst, f_src;
  assign f_op = INSTR[31:26];
  assign f_wz = INSTR[25];
  assign f_wc = INSTR[24];
  assign f_wr = INSTR[23];
  assign f_imm = INSTR[22];
  assign f_cond = INSTR[21:18];
  assign f_dst = INSTR[17:9];
  assign f_src = INSTR[8:0];

  logic go;
  assign go = INSTR_VALID && (f_cond == `RCH_COND_ALWAYS);

  // ----------------------------------------
  // counters and shadows
  // ----------------------------------------
  logic [31:0] phs_a, phs_b, shadow_rd;
  logic ld_a, ld_b, sh_we;
  rch_core_type s_r, s_nxt;

  assign sh_we = s_r.done && s_r.wr && is_phase(s_r.dst);
  assign ld_a = sh_we && (s_r.dst == `RCH_ADDR_PHA);
  assign ld_b = sh_we && (s_r.dst == `RCH_ADDR_PHB);

  rch_counter u_ctr_a (
    .clk(CLK_SYS),
    .rst_n(rst_n_r),
    .en(CTR_A_EN),
    .incr(CTR_A_INCR),
    .ld(ld_a),
    .ld_val(s_r.res),
    .phs(phs_a)
  );

  rch_counter u_ctr_b (
    .clk(CLK_SYS),
    .rst_n(rst_n_r),
    .en(CTR_B_EN),
    .incr(CTR_B_INCR),
    .ld(ld_b),
    .ld_val(s_r.res),
    .phs(phs_b)
  );

  // shadow read is registered and indexed by the held destination, so a new
  // instruction word on the port cannot disturb an operation in flight
  rch_shadow #(.DEPTH(2)) u_shadow (
    .clk(CLK_SYS),
    .we(sh_we),
    .waddr(s_r.dst[0]),
    .wdata(s_r.res),
    .raddr(s_r.dst[0]),
    .rdata(shadow_rd)
  );

  // ----------------------------------------
  // operand resolution
  // ----------------------------------------
  logic [31:0] src_eff;
  always_comb begin
    if (f_imm) begin
      src_eff = {23'h000000, f_src};
    end else if (f_src == `RCH_ADDR_PHA) begin
      src_eff = phs_a;
    end else if (f_src == `RCH_ADDR_PHB) begin
      src_eff = phs_b;
    end else begin
      src_eff = SRC_VAL;
    end
  end

  // destination held from issue; phase destinations replaced by shadow later
  logic [31:0] dst_hold_r, dst_hold_nxt;
  logic dst_phase_r, dst_phase_nxt;
  logic [4:0] rot_n_r, rot_n_nxt;
  logic rot_left_r, rot_left_nxt, c_hold_r, c_hold_nxt;
  // marks the cycle after a read strobe, when the fetched byte stands on the bus
  logic hub_rd_r, hub_rd_nxt;
  logic [31:0] dst_eff;
  assign dst_eff = dst_phase_r ? shadow_rd : dst_hold_r;

  // ----------------------------------------
  // hub window
  // ----------------------------------------
  logic my_slot;
  assign my_slot = (HUB_SLOT == CORE_ID);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    dst_hold_nxt = dst_hold_r;
    dst_phase_nxt = dst_phase_r;
    rot_n_nxt = rot_n_r;
    rot_left_nxt = rot_left_r;
    c_hold_nxt = c_hold_r;
    hub_rd_nxt = 1'b0;
    s_nxt.done = 1'b0;
    s_nxt.hub_req = 1'b0;
    case (s_r.st)
      RCH_IDLE: begin
        if (go) begin
          s_nxt.wz = f_wz;
          s_nxt.wc = f_wc;
          s_nxt.dst = f_dst;
          s_nxt.cnt = 5'h01;
          dst_hold_nxt = DST_VAL;
          dst_phase_nxt = is_phase(f_dst);
          c_hold_nxt = C_IN;
          if (f_op == `RCH_OP_RCL || f_op == `RCH_OP_RCR) begin
            s_nxt.st = RCH_ROT;
            s_nxt.busy = 1'b1;
            s_nxt.wr = f_wr;
            rot_left_nxt = (f_op == `RCH_OP_RCL);
            rot_n_nxt = src_eff[`RCH_CNT_W-1:0];
          end else if (f_op == `RCH_OP_HUBB) begin
            s_nxt.st = RCH_HUB;
            s_nxt.busy = 1'b1;
            s_nxt.hub_we = !f_wr;
            s_nxt.wr = f_wr;
            s_nxt.hub_addr = src_eff[15:0];
            s_nxt.hub_wdata = DST_VAL[7:0];
          end
        end
      end
      RCH_ROT: begin
        s_nxt.cnt = s_r.cnt + 5'h01;
        if ({2'b00, s_r.cnt} == `RCH_ROT_CLKS - 3'h1) begin
          s_nxt.res = rot_carry(dst_eff, rot_n_r, c_hold_r, rot_left_r);
          if (s_r.wz) begin
            s_nxt.zf = (rot_carry(dst_eff, rot_n_r, c_hold_r, rot_left_r)
                        == `RCH_ZERO32);
          end
          if (s_r.wc) begin
            s_nxt.cf = rot_left_r ? dst_eff[31] : dst_eff[0];
          end
          s_nxt.st = RCH_DONE;
        end
      end
      RCH_HUB: begin
        s_nxt.cnt = s_r.cnt + 5'h01;
        // access taken in own slot once the minimum has run, bounded by one rotation
        if ((my_slot && s_r.cnt >= `RCH_HUB_MIN - 5'h02) || s_r.cnt ==
            `RCH_HUB_MAX - 5'h02) begin
          s_nxt.hub_req = 1'b1;
          s_nxt.st = RCH_DONE;
        end
      end
      RCH_DONE: begin
        if (!s_r.hub_req) begin
          if (hub_rd_r) begin
            // the hub answers one cycle after the strobe
            s_nxt.res = {24'h000000, HUB_RDATA};
            if (s_r.wz) begin
              s_nxt.zf = (HUB_RDATA == 8'h00);
            end
          end
          s_nxt.done = 1'b1;
          s_nxt.busy = 1'b0;
          s_nxt.st = RCH_IDLE;
        end else begin
          hub_rd_nxt = !s_r.hub_we;
          if (s_r.wc) begin
            s_nxt.cf = 1'b0;
          end
        end
      end
      default: begin
        s_nxt.st = RCH_IDLE;
      end
    endcase
    if (s_r.st == RCH_IDLE && go && !(f_op == `RCH_OP_RCL || f_op == `RCH_OP_RCR ||
        f_op == `RCH_OP_HUBB)) begin
      s_nxt.zf = Z_IN;
    end
    if (s_r.st == RCH_IDLE && go) begin
      s_nxt.zf = Z_IN;
      s_nxt.cf = C_IN;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      s_r <= '0;
      dst_hold_r <= '0;
      dst_phase_r <= 1'b0;
      rot_n_r <= '0;
      rot_left_r <= 1'b0;
      c_hold_r <= 1'b0;
      hub_rd_r <= 1'b0;
    end else begin
      s_r <= s_nxt;
      dst_hold_r <= dst_hold_nxt;
      dst_phase_r <= dst_phase_nxt;
      rot_n_r <= rot_n_nxt;
      rot_left_r <= rot_left_nxt;
      c_hold_r <= c_hold_nxt;
      hub_rd_r <= hub_rd_nxt;
    end
  end

  logic [31:0] pha_r, phb_r;
  always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pha_r <= '0;
      phb_r <= '0;
    end else begin
      pha_r <= phs_a;
      phb_r <= phs_b;
    end
  end

  // ----------------------------------------
  // write-back strobe
  // ----------------------------------------
  // registered beside done so the strobe leaves a flip-flop like every output
  logic res_we_r;
  always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      res_we_r <= 1'b0;
    end else begin
      res_we_r <= s_nxt.done && s_nxt.wr;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign BUSY = s_r.busy;
  assign DONE = s_r.done;
  assign RES_WE = res_we_r;
  assign RES_ADDR = s_r.dst;
  assign RES = s_r.res;
  assign Z_OUT = s_r.zf;
  assign C_OUT = s_r.cf;
  assign HUB_REQ = s_r.hub_req;
  assign HUB_WE = s_r.hub_we;
  assign HUB_ADDR = s_r.hub_addr;
  assign HUB_WDATA = s_r.hub_wdata;
  assign PHASE_A = pha_r;
  assign PHASE_B = phb_r;
endmodule
`default_nettype wire

// ---- common/rch_defines.svh ----
`ifndef RCH_DEFINES_SVH
`define RCH_DEFINES_SVH
`define RCH_OP_RCL 6'h0D
`define RCH_OP_RCR 6'h0C
`define RCH_OP_HUBB 6'h00
`define RCH_COND_ALWAYS 4'hF
`define RCH_CNT_W 5
`define RCH_IMM_BYTE_W 9
`define RCH_ROT_CLKS 3'h4
`define RCH_HUB_MIN 5'h07
`define RCH_HUB_MAX 5'h16
`define RCH_HUB_PERIOD 5'h10
`define RCH_ZERO32 32'h0000_0000
`define RCH_ADDR_PHA 9'h1FC
`define RCH_ADDR_PHB 9'h1FD
`define RCH_ADDR_FQA 9'h1FA
`define RCH_ADDR_FQB 9'h1FB
`define RCH_ADDR_CTA 9'h1F8
`define RCH_ADDR_CTB 9'h1F9
`endif

// ---- common/rch_pkg.sv ----
`default_nettype none
package rch_pkg;
  typedef enum logic [1:0] {
    RCH_IDLE = 2'b00,
    RCH_ROT = 2'b01,
    RCH_HUB = 2'b10,
    RCH_DONE = 2'b11
  } rch_state_type;
  typedef struct packed {
    rch_state_type st;
    logic [4:0] cnt;
    logic [31:0] res;
    logic wr;
    logic [8:0] dst;
    logic zf;
    logic cf;
    logic wz;
    logic wc;
    logic busy;
    logic done;
    logic hub_req;
    logic hub_we;
    logic [15:0] hub_addr;
    logic [7:0] hub_wdata;
  } rch_core_type;
  typedef struct packed {
    logic [31:0] phs;
  } rch_ctr_type;
endpackage
`default_nettype wire

// ---- hw/rch_counter.sv ----
`default_nettype none
`include "rch_defines.svh"
module rch_counter import rch_pkg::*; (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronised reset
  input wire logic en, // accumulate enable from stimulus
  input wire logic [31:0] incr, // increment value
  input wire logic ld, // write-back into accumulator
  input wire logic [31:0] ld_val, // value written back
  output logic [31:0] phs // live accumulator
);
  rch_ctr_type s_r, s_nxt;
  always_comb begin
    s_nxt = s_r;
    if (ld) begin
      s_nxt.phs = ld_val;
    end else if (en) begin
      s_nxt.phs = s_r.phs + incr;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign phs = s_r.phs;
endmodule
`default_nettype wire

// ---- hw/rch_shadow.sv ----
`default_nettype none
`include "rch_defines.svh"
module rch_shadow import rch_pkg::*; #(
  parameter int DEPTH = 2
) (
  input wire logic clk, // system clock
  input wire logic we, // write strobe
  input wire logic [$clog2(DEPTH)-1:0] waddr, // write index
  input wire logic [31:0] wdata, // write data
  input wire logic [$clog2(DEPTH)-1:0] raddr, // read index
  output logic [31:0] rdata // registered read data
);
  logic [31:0] mem [DEPTH];
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// ---- tb/rch_core_checker.sv ----
`default_nettype none
module rch_core_checker (
  input wire logic CLK_SYS, // clock
  input wire logic RESETN, // reset
  input wire logic INSTR_VALID, // issue
  input wire logic [31:0] INSTR, // instruction
  input wire logic [31:0] DST_VAL, // destination value
  input wire logic [31:0] SRC_VAL, // source value
  input wire logic BUSY, // stall
  input wire logic DONE, // completion
  input wire logic RES_WE, // write-back
  input wire logic [31:0] RES, // result
  input wire logic Z_OUT, // zero flag
  input wire logic C_OUT, // carry flag
  input wire logic HUB_REQ, // hub strobe
  input wire logic HUB_WE, // hub write
  input wire logic [15:0] HUB_ADDR, // hub address
  input wire logic [7:0] HUB_RDATA // hub byte
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------
  // issue capture
  // --------
  logic go;
  logic [5:0] op_r;
  logic wz_r, wc_r, wr_r, cx_r;
  logic [15:0] a_r;
  assign go = INSTR_VALID && !BUSY && INSTR[21:18] == 4'hF;
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      {op_r, wz_r, wc_r, wr_r, cx_r, a_r} <= '1;
    end else if (go) begin
      {op_r, wz_r, wc_r, wr_r, cx_r, a_r} <= {INSTR[31:23],
        INSTR[26] ? DST_VAL[31] : DST_VAL[0], INSTR[22] ? {7'h00, INSTR[8:0]} : SRC_VAL[15:0]};
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  chk_done_pulse: assert property (DONE |=> !DONE)
    else $error("done longer than one cycle");
  chk_rot_time: assert property (go && INSTR[31:27] == 5'h06 |-> ##[4:5] DONE)
    else $error("rotate latency wrong");
  chk_hub_time: assert property (go && INSTR[31:26] == 6'h00 |-> ##[7:23] DONE)
    else $error("hub stall out of range");
  chk_rot_carry: assert property (DONE && op_r[5:1] == 5'h06 && wc_r |-> C_OUT == cx_r)
    else $error("rotate carry wrong");
  chk_zero_flag: assert property (DONE && wz_r && (op_r != 6'h00 || wr_r)
    |-> Z_OUT == (RES == 32'h0000_0000))
    else $error("zero flag wrong");
  chk_res_we: assert property (RES_WE |-> DONE && wr_r)
    else $error("write-back without result bit");
  chk_byte_zext: assert property (DONE && op_r == 6'h00 && wr_r |-> RES_WE && RES[31:8] == 24'h0)
    else $error("byte not zero-extended");
  chk_byte_data: assert property (HUB_REQ && !HUB_WE |-> ##2 DONE && RES[7:0] == $past(HUB_RDATA))
    else $error("fetched byte lost");
  chk_hub_addr: assert property (HUB_REQ |-> HUB_ADDR == a_r && HUB_WE == !wr_r)
    else $error("hub address or direction wrong");
  cov_rcl: cover property (DONE && op_r == 6'h0D);
  cov_rcr: cover property (DONE && op_r == 6'h0C);
  cov_read: cover property (HUB_REQ && !HUB_WE);
  cov_write: cover property (HUB_REQ && HUB_WE);
endmodule
bind rch_core rch_core_checker u_rch_core_checker (.CLK_SYS, .RESETN, .INSTR_VALID, .INSTR,
  .DST_VAL, .SRC_VAL, .BUSY, .DONE, .RES_WE, .RES, .Z_OUT, .C_OUT, .HUB_REQ, .HUB_WE,
  .HUB_ADDR, .HUB_RDATA);
`default_nettype wire

// ---- tb/rch_hub_model.sv ----
`default_nettype none
module rch_hub_model (
  input wire logic clk, // system clock
  input wire logic req, // access strobe
  input wire logic we, // byte write
  input wire logic [15:0] addr, // byte address
  input wire logic [7:0] wdata, // write byte
  output logic [3:0] slot, // round-robin slot
  output logic [7:0] rdata // read byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:511];
  logic [7:0] last;
  initial begin
    slot = 4'h0;
    rdata = 8'h00;
    last = 8'h00;
    for (int i = 0; i < 512; i++) mem[i] = i[7:0] ^ 8'hA5;
  end
  always @(posedge clk) begin
    slot <= slot + 4'h1;
    if (req && we) mem[addr[8:0]] <= wdata;
    if (req && !we) begin
      rdata <= mem[addr[8:0]];
      last <= mem[addr[8:0]];
    end else begin
      // bus released: never show the last byte
      rdata <= ~last;
    end
  end
endmodule
`default_nettype wire

// ---- tb/rotate_carry_hub_byte_read_tb.sv ----
`default_nettype none
module rotate_carry_hub_byte_read_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [31:0] d, s;
    logic c;
    logic [31:0] r;
    logic z, co;
  } rch_row_type;
  rch_row_type rows [14] = '{
    '{32'h8000_0000, 32'h0, 1'b1, 32'h8000_0000, 1'b0, 1'b1},
    '{32'h8000_0000, 32'h1, 1'b0, 32'h0, 1'b1, 1'b1},
    '{32'h8000_0000, 32'h1, 1'b1, 32'h1, 1'b0, 1'b1},
    '{32'h2108_4048, 32'h2, 1'b0, 32'h8421_0120, 1'b0, 1'b0},
    '{32'h2108_4048, 32'h2, 1'b1, 32'h8421_0123, 1'b0, 1'b0},
    '{32'h8765_4321, 32'h4, 1'b0, 32'h7654_3210, 1'b0, 1'b1},
    '{32'h8765_4321, 32'h4, 1'b1, 32'h7654_321F, 1'b0, 1'b1},
    '{32'h1, 32'h0, 1'b0, 32'h1, 1'b0, 1'b1},
    '{32'h1, 32'h1, 1'b0, 32'h0, 1'b1, 1'b1},
    '{32'h1, 32'h1, 1'b1, 32'h8000_0000, 1'b0, 1'b1},
    '{32'h18C2_1084, 32'h2, 1'b0, 32'h0630_8421, 1'b0, 1'b0},
    '{32'h18C2_1084, 32'h2, 1'b1, 32'hC630_8421, 1'b0, 1'b0},
    '{32'h8765_4321, 32'h4, 1'b0, 32'h0876_5432, 1'b0, 1'b1},
    '{32'h8765_4321, 32'h4, 1'b1, 32'hF876_5432, 1'b0, 1'b1}};
  logic clk, rstn, iv, cin, zin, cea, ceb, busy, done, rwe, zo, co, hreq, hwe;
  logic [31:0] ins, dv, sv, ia, ib, res, pa, pb, r_res, p0, q0;
  logic [8:0] raddr;
  logic [15:0] haddr;
  logic [7:0] hwd, hrd;
  logic [3:0] slot;
  logic r_we, r_z, r_c;
  int fails = 0;
  int checks = 0;
  rch_core u_rch_core (.CLK_SYS(clk), .RESETN(rstn), .INSTR_VALID(iv), .INSTR(ins),
    .DST_VAL(dv), .SRC_VAL(sv), .C_IN(cin), .Z_IN(zin), .HUB_SLOT(slot), .CORE_ID(4'h3),
    .HUB_RDATA(hrd), .CTR_A_EN(cea), .CTR_B_EN(ceb), .CTR_A_INCR(ia), .CTR_B_INCR(ib),
    .BUSY(busy), .DONE(done), .RES_WE(rwe), .RES_ADDR(raddr), .RES(res), .Z_OUT(zo),
    .C_OUT(co), .HUB_REQ(hreq), .HUB_WE(hwe), .HUB_ADDR(haddr), .HUB_WDATA(hwd),
    .PHASE_A(pa), .PHASE_B(pb));
  rch_hub_model u_rch_hub_model (.clk(clk), .req(hreq), .we(hwe), .addr(haddr),
    .wdata(hwd), .slot(slot), .rdata(hrd));
  always #4 clk = ~clk;
  // --------
  // helpers
  // --------
  function automatic logic [31:0] mk(logic [5:0] op, logic [3:0] fx, logic [8:0] s);
    return {op, fx, 4'hF, 9'h010, s};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic run(input logic [31:0] i, input logic [31:0] d, input logic [31:0] s,
                     input logic c);
    int n;
    @(posedge clk);
    {iv, ins, dv, sv, cin, zin} <= {1'b1, i, d, s, c, ~c};
    @(posedge clk);
    iv <= 1'b0;
    n = 0;
    #1;
    while (done !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 40) begin
      fails++;
      complete_run();
    end
    {r_res, r_we, r_z, r_c} = {res, rwe, zo, co};
  endtask
  initial begin
    {clk, rstn, iv, ins, dv, sv, cin, zin, cea, ceb} = '0;
    {ia, ib} = {32'h3, 32'h5};
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 14; k++) begin
      run(mk(k < 7 ? 6'h0D : 6'h0C, 4'hE, 9'h011), rows[k].d, rows[k].s, rows[k].c);
      check(r_res, rows[k].r);
      check({r_z, r_c, r_we}, {rows[k].z, rows[k].co, 1'b1});
    end
    run(mk(6'h0D, 4'hF, 9'h004), 32'h8765_4321, 32'hFFFF_FFFF, 1'b1);
    check(r_res, 32'h7654_321F);
    run(mk(6'h0D, 4'hE, 9'h011), 32'h8765_4321, 32'hFFFF_FFE4, 1'b1);
    check(r_res, 32'h7654_321F);
    run(mk(6'h0C, 4'hE, 9'h011), 32'h1, 32'h20, 1'b0);
    check({r_res, r_c}, {32'h1, 1'b1});
    run(mk(6'h0D, 4'hC, 9'h011), 32'h8000_0000, 32'h1, 1'b0);
    check({r_we, r_z, r_c}, 3'h3);
    run(mk(6'h00, 4'hF, 9'h15A), 32'h0, 32'h0, 1'b0);
    check(r_res, 32'h0000_00FF);
    check({raddr, r_we, r_z}, {9'h010, 1'b1, 1'b0});
    run(mk(6'h00, 4'hA, 9'h011), 32'h0, 32'h0000_00A5, 1'b0);
    check({r_z, r_res}, {1'b1, 32'h0});
    run(mk(6'h00, 4'h1, 9'h0A5), 32'h3C, 32'h0, 1'b0);
    check(r_we, 1'b0);
    run(mk(6'h00, 4'h3, 9'h0A5), 32'h0, 32'h0, 1'b0);
    check(r_res, 32'h3C);
    @(posedge clk);
    {cea, ceb} <= 2'b11;
    repeat (2) @(posedge clk);
    #1;
    {p0, q0} = {pa, pb};
    @(posedge clk);
    #1;
    check(pa - p0, 32'h3);
    check(pb - q0, 32'h5);
    @(posedge clk);
    cea <= 1'b0;
    // a byte read into the phase address loads shadow and accumulator together
    run({6'h00, 4'h3, 4'hF, 9'h1FC, 9'h15A}, 32'h0, 32'h0, 1'b0);
    repeat (3) @(posedge clk);
    #1;
    check(pa, 32'h0000_00FF);
    // the destination operand must come from the shadow, not the register value
    run({6'h0D, 4'h3, 4'hF, 9'h1FC, 9'h004}, 32'h1234_5678, 32'h0, 1'b1);
    repeat (3) @(posedge clk);
    #1;
    check(pa, 32'h0000_0FFF);
    run({6'h0D, 4'h2, 4'hF, 9'h010, 9'h1FC}, 32'h1, 32'h0, 1'b0);
    check(r_res, 32'h8000_0000);
    @(posedge clk);
    {iv, ins} <= {1'b1, mk(6'h0D, 4'h2, 9'h001) ^ 32'h0004_0000};
    @(posedge clk);
    iv <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    check({busy, done}, 2'h0);
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    #1;
    check({busy, done, rwe, hreq}, 4'h0);
    check(pa, 32'h0);
    check(pb, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
